/* testbench.sv */
`timescale 1ns/1ps

module testbench
    import toc_pkg::*;
;
    logic CLOCK;
    logic RSTN;
    logic HSEL;
    logic [31:0] HADDR;
    logic [1:0] HTRANS;
    logic HWRITE;
    logic [2:0] HSIZE;
    logic [23:0] addr_hi;
    logic [31:0] HWDATA;
    logic [31:0] HRDATA;
    logic HREADYOUT;
    logic HRESP;
    logic TIMER_OUT;
    logic pin;
    int failures;
    int cmp_count;
    logic [31:0] rdv;
    logic [1:0] tbl_edge [5] = '{2'b01, 2'b00, 2'b11, 2'b10, 2'b00};
    logic tbl_pin [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [31:0] tbl_cnt [5] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h0};

    toc_timer_top DUT (
        .CLOCK(CLOCK),
        .RSTN(RSTN),
        .HSEL(HSEL),
        .HADDR(HADDR),
        .HTRANS(HTRANS),
        .HWRITE(HWRITE),
        .HSIZE(HSIZE),
        .HWDATA(HWDATA),
        .HREADY(HREADYOUT),
        .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT),
        .HRESP(HRESP),
        .TIMER_INPUT_PIN0(pin),
        .TIMER_OUT(TIMER_OUT)
    );

    toc_pin_source src (
        .clk(CLOCK),
        .pin(pin)
    );

    always #5 CLOCK = ~CLOCK;

    // ==========================================================
    // verdict, the single exit point
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // ==========================================================
    // one AHB-Lite single transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        HSEL <= 1'b1;
        HADDR <= {addr_hi, a};
        HTRANS <= 2'b10;
        HWRITE <= wr;
        HSIZE <= 3'b010;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        if (HREADYOUT !== 1'b1) begin
            failures++;
            $display("FAIL %0t bus address phase timed out", $time);
            close_out();
        end
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= wd;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        rd = HRDATA;
        check({31'h0, HRESP}, 32'h0, "response not okay");
        if (n >= 50) begin
            failures++;
            $display("FAIL %0t bus wait timed out", $time);
            close_out();
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] v;
        xfer(1'b0, a, 32'h00000000, v);
        check(v, exp, msg);
    endtask : rd_chk

    // ==========================================================
    // main sequence
    initial begin
        CLOCK = 1'b0;
        RSTN = 1'b0;
        HSEL = 1'b0;
        HADDR = 32'h00000000;
        HTRANS = 2'b00;
        HWRITE = 1'b0;
        HSIZE = 3'b010;
        addr_hi = 24'h000000;
        HWDATA = 32'h00000000;
        failures = 0;
        cmp_count = 0;
        src.drive(1'b1);
        repeat (12) @(posedge CLOCK);
        RSTN <= 1'b1;
        @(posedge CLOCK);
        check({31'h0, TIMER_OUT}, 32'h0, "output after reset");
        rd_chk(OFS_OUTCTRL, 32'h0, "outctrl reset");
        wr(8'h20, 32'hffffffff);
        rd_chk(8'h20, 32'h0, "unmapped read");
        $display("test reset and map done");

        // edge seen at enable, against the level held when stopped
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CTRL, 32'h0);
            src.drive(tbl_pin[i]);
            repeat (2) @(posedge CLOCK);
            wr(OFS_PRESCALE, {28'h0, tbl_edge[i], 2'b00});
            wr(OFS_CTRL, 32'h5);
            repeat (6) @(posedge CLOCK);
            rd_chk(OFS_COUNT, tbl_cnt[i], "edge at enable");
        end
        $display("test edge at enable done");

        // base-clock sampling: one-cycle glitch dropped, two-cycle pulse counted
        wr(OFS_CTRL, 32'h0);
        src.drive(1'b0);
        wr(OFS_PRESCALE, 32'h4);
        wr(OFS_CTRL, 32'h5);
        repeat (6) @(posedge CLOCK);
        src.pulse(1);
        repeat (6) @(posedge CLOCK);
        rd_chk(OFS_COUNT, 32'h0, "glitch counted");
        src.pulse(2);
        repeat (6) @(posedge CLOCK);
        rd_chk(OFS_COUNT, 32'h1, "short pulse missed on base clock");
        $display("test count filter done");

        // capture sampling on the divided clock: 10 cycles is too short at /16
        wr(OFS_CTRL, 32'h0);
        wr(OFS_PRESCALE, 32'h6);
        wr(OFS_CTRL, 32'h9);
        repeat (64) @(posedge CLOCK);
        src.pulse(10);
        repeat (40) @(posedge CLOCK);
        rd_chk(OFS_CAPTURE, 32'h0, "short capture taken");
        src.pulse(40);
        repeat (40) @(posedge CLOCK);
        xfer(1'b0, OFS_CAPTURE, 32'h0, rdv);
        check({31'h0, rdv != 32'h0}, 32'h1, "long capture missed");
        // pin clear-start: edge filtered at E2, count cleared at E3, read sees E9
        wr(OFS_CTRL, 32'h0);
        wr(OFS_PRESCALE, 32'h4);
        wr(OFS_CTRL, 32'h11);
        repeat (4) @(posedge CLOCK);
        src.pulse(8);
        rd_chk(OFS_COUNT, 32'h6, "pin clear-start");
        $display("test capture filter done");

        // level set and reset, write-only bits read back zero
        wr(OFS_CTRL, 32'h0);
        wr(OFS_OUTCTRL, 32'h3);
        repeat (2) @(posedge CLOCK);
        check({31'h0, TIMER_OUT}, 32'h1, "level set");
        // upper address bits alias: only the low byte is decoded
        addr_hi = 24'h5a5a5a;
        rd_chk(OFS_OUTCTRL, 32'h1, "set bits read");
        addr_hi = 24'h000000;
        wr(OFS_OUTCTRL, 32'h5);
        repeat (2) @(posedge CLOCK);
        check({31'h0, TIMER_OUT}, 32'h0, "level reset");
        rd_chk(OFS_OUTCTRL, 32'h1, "reset bits read");
        $display("test output level done");

        // one-shot trigger clears itself; retrigger spaced two count clocks
        wr(OFS_PRESCALE, 32'h4);
        wr(OFS_CTRL, 32'h3);
        wr(OFS_OUTCTRL, 32'h9);
        repeat (6) @(posedge CLOCK);
        check({31'h0, TIMER_OUT}, 32'h1, "one-shot start");
        rd_chk(OFS_OUTCTRL, 32'h1, "trigger read");
        xfer(1'b0, OFS_STATUS, 32'h0, rdv);
        check(rdv & 32'h3, 32'h1, "trigger still pending");
        repeat (2) @(posedge CLOCK);
        wr(OFS_OUTCTRL, 32'h9);
        repeat (6) @(posedge CLOCK);
        rd_chk(OFS_OUTCTRL, 32'h1, "retrigger read");
        wr(OFS_CTRL, 32'h0);
        wr(OFS_OUTCTRL, 32'h5);
        repeat (2) @(posedge CLOCK);
        check({31'h0, TIMER_OUT}, 32'h0, "output cleared");
        $display("test one-shot done");

        // reset in mid-run while the output is high
        wr(OFS_OUTCTRL, 32'h3);
        repeat (2) @(posedge CLOCK);
        check({31'h0, TIMER_OUT}, 32'h1, "level set again");
        RSTN <= 1'b0;
        @(posedge CLOCK);
        RSTN <= 1'b1;
        repeat (2) @(posedge CLOCK);
        check({31'h0, TIMER_OUT}, 32'h0, "output after mid-run reset");
        rd_chk(OFS_OUTCTRL, 32'h0, "outctrl after mid-run reset");
        $display("test mid-run reset done");
        close_out();
    end

endmodule : testbench

/* toc_edge_filter.sv */
`timescale 1ns/1ps

module toc_edge_filter
    import toc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic sample,
    input wire logic pin,
    input toc_edge_t edge_sel,
    output logic level,
    output logic edge_pulse
);

    // ==========================================================
    // two-sample filter
    logic last;
    logic rise;

    assign rise = pin & ~level;

    // frozen while stopped: the held level is compared on restart, so a
    // pin that moved during the stop shows up as an edge at enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last <= 1'b0;
            level <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            edge_pulse <= 1'b0;
            if (run && sample) begin
                last <= pin;
                if (last == pin && pin != level) begin
                    level <= pin;
                    unique case (edge_sel)
                        EDGE_FALL: edge_pulse <= ~rise;
                        EDGE_RISE: edge_pulse <= rise;
                        EDGE_NONE: edge_pulse <= 1'b0;
                        EDGE_BOTH: edge_pulse <= 1'b1;
                    endcase
                end
            end
        end
    end

    property p_edge_needs_two_samples;
        @(posedge clk) disable iff (!rstn)
        edge_pulse |-> (level != $past(level)) && (level == $past(last));
    endproperty
    a_edge_needs_two_samples: assert property (p_edge_needs_two_samples)
        else $error("edge reported without two equal samples");

endmodule : toc_edge_filter

/* toc_pin_source.sv */
`timescale 1ns/1ps

// ==========================================================
// external signal source on the timer input pin
// the pin is driven synchronously, so it always shows a firm level
module toc_pin_source (
    input wire logic clk,
    output logic pin
);

    initial begin
        pin = 1'b0;
    end

    // ==========================================================
    // level change, held until the next call
    task automatic drive(input logic level);
        @(posedge clk);
        pin <= level;
    endtask : drive

    // ==========================================================
    // high pulse of a chosen width, short ones probe the noise filter
    task automatic pulse(input int width);
        @(posedge clk);
        pin <= 1'b1;
        repeat (width) @(posedge clk);
        pin <= 1'b0;
    endtask : pulse

endmodule : toc_pin_source

/* toc_pkg.sv */
package toc_pkg;

    // ==========================================================
    // register map (byte addresses, low eight address bits)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PRESCALE = 8'h04;
    localparam logic [7:0] OFS_OUTCTRL = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0c;
    localparam logic [7:0] OFS_CAPTURE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ==========================================================
    // timer_output_control field positions
    localparam int OC_ENABLE = 0;
    localparam int OC_SET = 1;
    localparam int OC_RESET = 2;
    localparam int OC_TRIG = 3;

    // ==========================================================
    // status field positions
    localparam int ST_OUT_LEVEL = 0;
    localparam int ST_TRIG_PEND = 1;
    localparam int ST_PIN_LEVEL = 2;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        EDGE_FALL = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_NONE = 2'b10,
        EDGE_BOTH = 2'b11
    } toc_edge_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ_WAIT = 2'b10,
        BUS_READ_DONE = 2'b11
    } toc_bus_t;

    typedef struct packed {
        logic pin_clear;
        logic pin_capture;
        logic pin_count;
        logic oneshot_mode;
        logic run;
    } toc_ctrl_t;

    typedef struct packed {
        toc_edge_t edge_sel;
        logic [1:0] div_sel;
    } toc_presc_t;

    // ==========================================================
    // reset values and counts
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [3:0] PRESC_RESET = 4'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [7:0] PRESC_RESET_CNT = 8'h00;
    // divide masks for div_sel 0..3: /1, /4, /16, /64
    localparam logic [31:0] DIV_MASKS = 32'h3f0f0300;

endpackage : toc_pkg

/* toc_prescaler.sv */
`timescale 1ns/1ps

module toc_prescaler
    import toc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [1:0] div_sel,
    output logic tick
);

    // ==========================================================
    // divider
    logic [7:0] cnt;
    logic [7:0] mask;

    assign mask = DIV_MASKS[{div_sel, 3'b000} +: 8];

    // held in reset while stopped so every start has the same phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= PRESC_RESET_CNT;
            tick <= 1'b0;
        end else if (!run) begin
            cnt <= PRESC_RESET_CNT;
            tick <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
            tick <= ((cnt & mask) == mask);
        end
    end

endmodule : toc_prescaler

/* toc_timer_top.sv */
// What this block does
// - level-set and level-reset bits always read back as zero.
// - one-shot trigger bit clears itself and reads back as zero.
// - pin high after reset gives a rising edge at first enable.
// - pin fell while stopped gives a falling edge at enable.
// - pin rose while stopped gives a rising edge at enable.
// - filter samples on base clock for counting, count clock for capture.
// - capture needs the new level on two successive samples.
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

module toc_timer_top
    import toc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic TIMER_INPUT_PIN0,
    output logic TIMER_OUT
);

    // ==========================================================
    // bus slave
    toc_bus_t bus_state;
    toc_bus_t next_bus_state;
    logic [7:0] bus_addr;
    logic accept;

    // hsize is not decoded: only whole-word transfers are supported
    assign accept = HSEL & HTRANS[1] & HREADY;
    assign HREADYOUT = (bus_state != BUS_READ_WAIT);
    assign HRESP = 1'b0;

    always_comb begin
        next_bus_state = BUS_IDLE;
        unique case (bus_state)
            BUS_READ_WAIT: next_bus_state = BUS_READ_DONE;
            BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
                if (accept) begin
                    next_bus_state = HWRITE ? BUS_WRITE : BUS_READ_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            bus_state <= BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            bus_addr <= 8'h00;
        end else if (accept) begin
            bus_addr <= HADDR[7:0];
        end
    end

    // ==========================================================
    // register state
    toc_ctrl_t ctrl;
    toc_presc_t presc;
    logic out_enable;
    logic out_ff;
    logic trig_pend;
    logic [15:0] count;
    logic [15:0] capture;
    logic wr_ctrl;
    logic wr_presc;
    logic wr_oc;
    logic oc_set;
    logic oc_reset;
    logic trig_write;

    assign wr_ctrl = (bus_state == BUS_WRITE) && (bus_addr == OFS_CTRL);
    assign wr_presc = (bus_state == BUS_WRITE) && (bus_addr == OFS_PRESCALE);
    assign wr_oc = (bus_state == BUS_WRITE) && (bus_addr == OFS_OUTCTRL);
    assign oc_set = wr_oc & HWDATA[OC_SET];
    assign oc_reset = wr_oc & HWDATA[OC_RESET];
    // a trigger outside a running one-shot setup is dropped
    assign trig_write = wr_oc & HWDATA[OC_TRIG] & ctrl.oneshot_mode & ctrl.run;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl <= toc_ctrl_t'(CTRL_RESET);
        end else if (wr_ctrl) begin
            ctrl <= toc_ctrl_t'(HWDATA[4:0]);
        end
    end

    // taken as written; changing it while running is software's hazard
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            presc <= toc_presc_t'(PRESC_RESET);
        end else if (wr_presc) begin
            presc <= toc_presc_t'(HWDATA[3:0]);
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            out_enable <= 1'b0;
        end else if (wr_oc) begin
            out_enable <= HWDATA[OC_ENABLE];
        end
    end

    // ==========================================================
    // count clock and pin filter
    logic presc_tick;
    logic filt_sample;
    logic filt_level;
    logic filt_edge;
    logic count_tick;
    logic trig_take;

    toc_prescaler u_prescaler (
        .clk(CLOCK),
        .rstn(RSTN),
        .run(ctrl.run),
        .div_sel(presc.div_sel),
        .tick(presc_tick)
    );

    // counting on the pin wants every base clock; capture uses the slower
    // count clock, which rejects more noise but adds latency
    assign filt_sample = ctrl.pin_count ? 1'b1 : presc_tick;

    toc_edge_filter u_edge_filter (
        .clk(CLOCK),
        .rstn(RSTN),
        .run(ctrl.run),
        .sample(filt_sample),
        .pin(TIMER_INPUT_PIN0),
        .edge_sel(presc.edge_sel),
        .level(filt_level),
        .edge_pulse(filt_edge)
    );

    assign count_tick = ctrl.pin_count ? filt_edge : presc_tick;
    assign trig_take = trig_pend & presc_tick;

    // ==========================================================
    // one-shot trigger: held until the next count clock, read back only through the status register
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            trig_pend <= 1'b0;
        end else if (trig_write) begin
            trig_pend <= 1'b1;
        end else if (presc_tick) begin
            trig_pend <= 1'b0;
        end
    end

    // ==========================================================
    // counter and capture
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            count <= COUNT_RESET;
        end else if (!ctrl.run) begin
            count <= COUNT_RESET;
        end else if (trig_take || (ctrl.pin_clear && !ctrl.pin_count && filt_edge)) begin
            count <= COUNT_RESET;
        end else if (count_tick) begin
            count <= count + 16'h0001;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            capture <= COUNT_RESET;
        end else if (ctrl.run && ctrl.pin_capture && !ctrl.pin_count && filt_edge) begin
            capture <= count;
        end
    end

    // ==========================================================
    // output flip-flop: a set or reset write wins over the one-shot sequence, unless both bits are written together
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            out_ff <= 1'b0;
        end else if (oc_set && !oc_reset) begin
            out_ff <= 1'b1;
        end else if (oc_reset && !oc_set) begin
            out_ff <= 1'b0;
        end else if (ctrl.oneshot_mode && trig_take) begin
            out_ff <= 1'b1;
        end else if (ctrl.oneshot_mode && count_tick && count == COUNT_MAX) begin
            out_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            TIMER_OUT <= 1'b0;
        end else begin
            TIMER_OUT <= out_enable & out_ff;
        end
    end

    // ==========================================================
    // read data, loaded in the wait cycle so earlier writes are visible
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (bus_addr)
            OFS_CTRL: rd_mux[4:0] = ctrl;
            OFS_PRESCALE: rd_mux[3:0] = presc;
            OFS_OUTCTRL: rd_mux[OC_ENABLE] = out_enable;
            OFS_COUNT: rd_mux[15:0] = count;
            OFS_CAPTURE: rd_mux[15:0] = capture;
            OFS_STATUS: begin
                rd_mux[ST_OUT_LEVEL] = out_ff;
                rd_mux[ST_TRIG_PEND] = trig_pend;
                rd_mux[ST_PIN_LEVEL] = filt_level;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            HRDATA <= 32'h0000_0000;
        end else if (bus_state == BUS_READ_WAIT) begin
            HRDATA <= rd_mux;
        end
    end

    // ==========================================================
    // checks
    property p_oc_reads_zero;
        @(posedge CLOCK) disable iff (!RSTN)
        (bus_state == BUS_READ_WAIT && bus_addr == OFS_OUTCTRL)
            |=> HREADYOUT && HRDATA[OC_TRIG:OC_SET] == 3'h0;
    endproperty
    a_oc_reads_zero: assert property (p_oc_reads_zero)
        else $error("output control read returned nonzero write-only bits");

    property p_trig_clears;
        @(posedge CLOCK) disable iff (!RSTN)
        (trig_pend && presc_tick && !trig_write) |=> !trig_pend;
    endproperty
    a_trig_clears: assert property (p_trig_clears)
        else $error("one-shot trigger did not clear after its count clock");

    property p_trig_only_oneshot;
        @(posedge CLOCK) disable iff (!RSTN)
        (!trig_pend && !ctrl.oneshot_mode) |=> !trig_pend;
    endproperty
    a_trig_only_oneshot: assert property (p_trig_only_oneshot)
        else $error("trigger accepted outside one-shot mode");

    property p_level_set;
        @(posedge CLOCK) disable iff (!RSTN)
        (oc_set && !oc_reset && HWDATA[OC_ENABLE]) |=> out_ff ##1 TIMER_OUT;
    endproperty
    a_level_set: assert property (p_level_set)
        else $error("level set did not drive the output high");

    property p_level_reset;
        @(posedge CLOCK) disable iff (!RSTN)
        (oc_reset && !oc_set) |=> !out_ff ##1 !TIMER_OUT;
    endproperty
    a_level_reset: assert property (p_level_reset)
        else $error("level reset did not drive the output low");

    property p_fast_sampling;
        @(posedge CLOCK) disable iff (!RSTN)
        (ctrl.run && ctrl.pin_count && TIMER_INPUT_PIN0 && !filt_level) [*2] |=> filt_level;
    endproperty
    a_fast_sampling: assert property (p_fast_sampling)
        else $error("pin count mode did not filter on the base clock");

    property p_slow_sampling;
        @(posedge CLOCK) disable iff (!RSTN)
        (!ctrl.pin_count && !presc_tick) |=> $stable(filt_level) && !filt_edge;
    endproperty
    a_slow_sampling: assert property (p_slow_sampling)
        else $error("capture filter moved without a count clock");

    property p_rise_at_enable;
        @(posedge CLOCK) disable iff (!RSTN)
        ($rose(ctrl.run) && ctrl.pin_count && presc.edge_sel == EDGE_RISE
            && TIMER_INPUT_PIN0 && !filt_level)
            ##1 (ctrl.run && ctrl.pin_count && TIMER_INPUT_PIN0) |-> ##[0:1] filt_edge;
    endproperty
    a_rise_at_enable: assert property (p_rise_at_enable)
        else $error("rising edge not detected at enable");

    property p_fall_at_enable;
        @(posedge CLOCK) disable iff (!RSTN)
        ($rose(ctrl.run) && ctrl.pin_count && presc.edge_sel == EDGE_FALL
            && !TIMER_INPUT_PIN0 && filt_level)
            ##1 (ctrl.run && ctrl.pin_count && !TIMER_INPUT_PIN0) |-> ##[0:1] filt_edge;
    endproperty
    a_fall_at_enable: assert property (p_fall_at_enable)
        else $error("falling edge not detected at enable");

endmodule : toc_timer_top
